// >>> core/dcr_config_eq.v
// configuration and equalizer gain registers of the serial audio-link deserializer
//
// Function
// - bit 7 enables forward parity checker
// - bit 6 enables back-channel CRC generation
// - bit 5 enables io supply auto-detect
// - bit 4 picks 3.3V or 1.8V io
// - bit 3 gates i2c pass-through forwarding
// - auto-acked writes retarget to remote id
// - bit 1 clears parity counters, self-clears
// - bit 0 picks sample clock edge
// - manual gain used when adaptive bypassed
// - gain codes are thermometer attenuation steps
// - remote id auto-loads after lock unless frozen
`timescale 1ns/10ps
`default_nettype none
`include "dcr_regs.vh"

module dcr_config_eq #(
	parameter AW = 8, // register offset width
	parameter DW = 8 // register data width
) (
	// clock and reset
	input wire i_sys_clk,
	input wire i_rst,
	// register access from the i2c target or the control channel
	input wire [AW-1:0] i_reg_addr,
	input wire [DW-1:0] i_reg_wdata,
	input wire i_reg_wr,
	input wire i_reg_rd,
	output reg [DW-1:0] o_reg_rdata,
	output reg o_reg_rvalid,
	// link status and forward-channel id
	input wire i_rx_lock,
	input wire [6:0] i_fwd_ser_id,
	input wire i_fwd_ser_id_valid,
	// equalizer
	input wire i_aeq_bypass,
	input wire [DW-1:0] i_adaptive_gain,
	output reg [DW-1:0] o_line_gain,
	output reg [DW-1:0] o_manual_atten_tenths,
	// remote write handling from the local i2c target
	input wire i_rmt_wr_req,
	input wire i_rmt_ack,
	output reg o_local_ack,
	output reg o_local_nak,
	output reg o_fwd_req,
	output reg [6:0] o_fwd_dev,
	// configuration levels to the datapaths
	output reg o_parity_check_en,
	output reg o_crc_gen_en,
	output reg o_io_auto_detect,
	output reg o_io_supply_3v3,
	output reg o_pass_through_en,
	output reg o_sample_edge_rising,
	output reg o_parity_cnt_clear,
	output reg o_rx_locked
);

	// remote write states
	localparam ST_IDLE = 2'h0; // no remote write in flight
	localparam ST_WAIT = 2'h1; // forwarded, waiting for the remote acknowledge
	localparam ST_POST = 2'h2; // acknowledged early, remote answer still due
	// the fourth code is never entered; the default branch steers it back to idle

	// register storage
	reg [DW-1:0] general_config_one; // config bits, parity clear bit self-clears
	reg [DW-1:0] equalizer_gain_control; // manual_line_gain
	reg [DW-1:0] remote_ser_id; // id in 7:1, freeze in 0
	reg [1:0] state; // remote write state
	reg [1:0] next_state; // its next value
	reg [DW-1:0] next_rdata; // read mux
	reg [DW-1:0] next_atten; // decoded attenuation
	wire rx_lock_s; // lock level after the synchroniser
	wire aeq_bypass_s; // bypass level after the synchroniser
	wire wr_cfg; // write strobe for general_config_one
	wire wr_eq; // write strobe for equalizer_gain_control
	wire wr_rid; // write strobe for remote_ser_id
	wire rid_usable; // remote id set and pass-through on
	wire auto_ack; // auto-acknowledge bit

	// lock and bypass come from the analog front end, another domain
	// both share one two-stage synchroniser; they are unrelated, so skew between them is harmless
	dcr_sync2 #(
		.WIDTH(2)
	) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_async({i_rx_lock, i_aeq_bypass}),
		.o_sync({rx_lock_s, aeq_bypass_s})
	);

	// address decode
	// only offsets in the map are decoded; any other write is dropped
	assign wr_cfg = i_reg_wr && (i_reg_addr == `DCR_OFS_GENERAL_CONFIG_ONE);
	assign wr_eq = i_reg_wr && (i_reg_addr == `DCR_OFS_EQUALIZER_GAIN_CONTROL);
	assign wr_rid = i_reg_wr && (i_reg_addr == `DCR_OFS_REMOTE_SER_ID);

	// a zero id disables remote access, so no forward happens then
	assign rid_usable = general_config_one[`DCR_BIT_PASS_THROUGH] &&
		(remote_ser_id[`DCR_RID_MSB:`DCR_RID_LSB] != `DCR_RID_NONE);
	assign auto_ack = general_config_one[`DCR_BIT_AUTO_ACK];

	// general_config_one: plain storage except the self-clearing clear bit
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			// reset value enables parity, crc, auto-detect, pass-through and rising edge
			general_config_one <= `DCR_RST_GENERAL_CONFIG_ONE;
		end else if (wr_cfg) begin
			// full byte write; setting bit 1 again here restarts the clear
			general_config_one <= i_reg_wdata;
		end else begin
			// clear pulse goes out this cycle, so the bit drops and reads zero after it
			general_config_one[`DCR_BIT_PARITY_CNT_CLEAR] <= 1'b0;
		end
	end

	// clear pulse to the parity error counters, one cycle per write of one
	// the write cycle itself is masked, so a rewrite of one still gives a single pulse
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_parity_cnt_clear <= 1'b0;
		end else begin
			o_parity_cnt_clear <= general_config_one[`DCR_BIT_PARITY_CNT_CLEAR] && !wr_cfg;
		end
	end

	// equalizer gain register
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			equalizer_gain_control <= `DCR_RST_EQUALIZER_GAIN_CONTROL;
		end else if (wr_eq) begin
			// any byte is stored; codes off the ladder are only flagged by the decoder
			equalizer_gain_control <= i_reg_wdata;
		end
	end

	// remote id: software write wins over the auto-load so a frozen write sticks
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			// zero id keeps forwarding off until the link supplies one
			remote_ser_id <= `DCR_RST_REMOTE_SER_ID;
		end else if (wr_rid) begin
			// the freeze bit is written together with the id
			remote_ser_id <= i_reg_wdata;
		end else if (rx_lock_s && i_fwd_ser_id_valid && !remote_ser_id[`DCR_BIT_FREEZE_ID]) begin
			// forward channel supplies the id once locked
			remote_ser_id[`DCR_RID_MSB:`DCR_RID_LSB] <= i_fwd_ser_id;
		end
	end

	// configuration levels, each straight from a flop
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			// levels stay low in reset; register reset values show one edge after release
			o_parity_check_en <= 1'b0;
			o_crc_gen_en <= 1'b0;
			o_io_auto_detect <= 1'b0;
			o_io_supply_3v3 <= 1'b0;
			o_pass_through_en <= 1'b0;
			o_sample_edge_rising <= 1'b0;
			o_rx_locked <= 1'b0;
		end else begin
			// one flop of delay from each register bit to its datapath level
			o_parity_check_en <= general_config_one[`DCR_BIT_PARITY_CHECK_EN];
			o_crc_gen_en <= general_config_one[`DCR_BIT_CRC_GEN_EN];
			o_io_auto_detect <= general_config_one[`DCR_BIT_IO_AUTO_DETECT];
			o_io_supply_3v3 <= general_config_one[`DCR_BIT_IO_SUPPLY_3V3];
			o_pass_through_en <= general_config_one[`DCR_BIT_PASS_THROUGH];
			o_sample_edge_rising <= general_config_one[`DCR_BIT_SAMPLE_EDGE_SELECT];
			o_rx_locked <= rx_lock_s;
		end
	end

	// decode manual_line_gain into attenuation; codes outside the ladder are flagged
	always @* begin
		case (equalizer_gain_control)
			`DCR_GAIN_CODE_0: next_atten = `DCR_ATTEN_0;
			`DCR_GAIN_CODE_1: next_atten = `DCR_ATTEN_1;
			`DCR_GAIN_CODE_2: next_atten = `DCR_ATTEN_2;
			`DCR_GAIN_CODE_3: next_atten = `DCR_ATTEN_3;
			`DCR_GAIN_CODE_4: next_atten = `DCR_ATTEN_4;
			`DCR_GAIN_CODE_5: next_atten = `DCR_ATTEN_5;
			`DCR_GAIN_CODE_6: next_atten = `DCR_ATTEN_6;
			default: next_atten = `DCR_ATTEN_INVALID;
		endcase
	end

	// equalizer gain select: manual register only while adaptive is bypassed
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_line_gain <= `DCR_RST_EQUALIZER_GAIN_CONTROL;
			o_manual_atten_tenths <= `DCR_ATTEN_0;
		end else begin
			// bypass is synchronised, so a change on its pin lands three edges later
			o_line_gain <= aeq_bypass_s ? equalizer_gain_control : i_adaptive_gain;
			o_manual_atten_tenths <= next_atten;
		end
	end

	// remote write state machine
	// auto-ack is honoured even unlocked; software is trusted to set it only when locked
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				// a request is taken only here; others are ignored while one is in flight
				if (i_rmt_wr_req && rid_usable) begin
					next_state = auto_ack ? ST_POST : ST_WAIT;
				end
			end
			ST_WAIT: begin
				// a far side that never answers leaves the local master waiting here
				if (i_rmt_ack) begin
					next_state = ST_IDLE;
				end
			end
			ST_POST: begin
				// the remote answer only closes the transfer
				if (i_rmt_ack) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				// unused code returns to idle
				next_state = ST_IDLE;
			end
		endcase
	end

	// state register and remote write outputs
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			state <= ST_IDLE;
			o_local_ack <= 1'b0;
			o_local_nak <= 1'b0;
			o_fwd_req <= 1'b0;
			// forwarded address starts at the none id
			o_fwd_dev <= `DCR_RID_NONE;
		end else begin
			state <= next_state;
			o_local_ack <= 1'b0;
			o_local_nak <= 1'b0;
			o_fwd_req <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (i_rmt_wr_req && rid_usable) begin
						// retarget to the stored remote id before it crosses the link
						o_fwd_req <= 1'b1;
						o_fwd_dev <= remote_ser_id[`DCR_RID_MSB:`DCR_RID_LSB];
						o_local_ack <= auto_ack;
					end else if (i_rmt_wr_req) begin
						// pass-through off or no remote id: refuse locally
						o_local_nak <= 1'b1;
					end
				end
				ST_WAIT: begin
					// without auto-ack the local master waits for the remote answer
					o_local_ack <= i_rmt_ack;
				end
				ST_POST: begin
					// already acknowledged; the remote answer is swallowed
					o_local_ack <= 1'b0;
				end
				default: begin
					o_local_ack <= 1'b0;
				end
			endcase
		end
	end

	// read mux; unmapped offsets read zero
	// the mux is combinational here and registered below, so the bus sees a flop
	always @* begin
		case (i_reg_addr)
			`DCR_OFS_GENERAL_CONFIG_ONE: next_rdata = general_config_one;
			`DCR_OFS_EQUALIZER_GAIN_CONTROL: next_rdata = equalizer_gain_control;
			`DCR_OFS_REMOTE_SER_ID: next_rdata = remote_ser_id;
			default: next_rdata = `DCR_READ_UNMAPPED;
		endcase
	end

	// registered read answer, one cycle after the strobe
	// rdata holds between reads so a slow master can still pick it up
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_reg_rdata <= `DCR_READ_UNMAPPED;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				o_reg_rdata <= next_rdata;
			end
		end
	end

endmodule

`default_nettype wire

// >>> shared/dcr_regs.vh
// register map, field positions, reset values and gain codes of the deserializer config bank
`ifndef DCR_REGS_VH
`define DCR_REGS_VH

// register offsets
`define DCR_OFS_GENERAL_CONFIG_ONE 8'h03
`define DCR_OFS_EQUALIZER_GAIN_CONTROL 8'h04
`define DCR_OFS_REMOTE_SER_ID 8'h06

// reset values
`define DCR_RST_GENERAL_CONFIG_ONE 8'hE9
`define DCR_RST_EQUALIZER_GAIN_CONTROL 8'h00
`define DCR_RST_REMOTE_SER_ID 8'h00

// general_config_one field positions
`define DCR_BIT_PARITY_CHECK_EN 7
`define DCR_BIT_CRC_GEN_EN 6
`define DCR_BIT_IO_AUTO_DETECT 5
`define DCR_BIT_IO_SUPPLY_3V3 4
`define DCR_BIT_PASS_THROUGH 3
`define DCR_BIT_AUTO_ACK 2
`define DCR_BIT_PARITY_CNT_CLEAR 1
`define DCR_BIT_SAMPLE_EDGE_SELECT 0

// remote serializer id register layout
`define DCR_BIT_FREEZE_ID 0
`define DCR_RID_MSB 7
`define DCR_RID_LSB 1
`define DCR_RID_NONE 7'h00

// manual_line_gain codes (thermometer style)
`define DCR_GAIN_CODE_0 8'h00
`define DCR_GAIN_CODE_1 8'h01
`define DCR_GAIN_CODE_2 8'h03
`define DCR_GAIN_CODE_3 8'h07
`define DCR_GAIN_CODE_4 8'h0F
`define DCR_GAIN_CODE_5 8'h1F
`define DCR_GAIN_CODE_6 8'h3F

// attenuation in tenths of a dB for each code
`define DCR_ATTEN_0 8'h00
`define DCR_ATTEN_1 8'h2D
`define DCR_ATTEN_2 8'h41
`define DCR_ATTEN_3 8'h4B
`define DCR_ATTEN_4 8'h50
`define DCR_ATTEN_5 8'h6E
`define DCR_ATTEN_6 8'h7D
`define DCR_ATTEN_INVALID 8'hFF

// read value of unmapped offsets
`define DCR_READ_UNMAPPED 8'h00

`endif

// >>> core/dcr_sync2.v
// two flip-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/10ps
`default_nettype none

module dcr_sync2 #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire i_sys_clk,
	input wire i_rst,
	// asynchronous level in
	input wire [WIDTH-1:0] i_async,
	// synchronised level out
	output reg [WIDTH-1:0] o_sync
);

	// first stage, read only by the second stage
	reg [WIDTH-1:0] meta;

	// two stages give the first one a full cycle to settle
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			meta <= {WIDTH{1'b0}};
			o_sync <= {WIDTH{1'b0}};
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end

endmodule

`default_nettype wire

// >>> tb/dcr_config_eq_assertions.sv
// concurrent checks on the config and gain register bank ports
`timescale 1ns/10ps
`default_nettype none
module dcr_config_eq_assertions (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// register bus
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_reg_rvalid,
	// remote writes
	input wire logic i_rmt_wr_req,
	input wire logic i_rmt_ack,
	input wire logic o_local_ack,
	input wire logic o_fwd_req,
	// config levels, pulse and gain decode
	input wire logic o_parity_check_en,
	input wire logic o_crc_gen_en,
	input wire logic o_io_auto_detect,
	input wire logic o_io_supply_3v3,
	input wire logic o_pass_through_en,
	input wire logic o_sample_edge_rising,
	input wire logic o_parity_cnt_clear,
	input wire logic [7:0] o_manual_atten_tenths
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// write to the config register, and one that sets the clear bit
	sequence s_cfg_wr; i_reg_wr && i_reg_addr == 8'h03; endsequence
	sequence s_clr_wr; s_cfg_wr ##0 i_reg_wdata[1]; endsequence
	// a level output follows its written bit two edges later
	property p_bit(int b, logic o);
		s_cfg_wr |-> ##2 o == $past(i_reg_wdata[b], 2);
	endproperty
	chk_parity_en: assert property (p_bit(7, o_parity_check_en))
		else $error("parity enable wrong");
	chk_crc_en: assert property (p_bit(6, o_crc_gen_en))
		else $error("crc enable wrong");
	chk_io_detect: assert property (p_bit(5, o_io_auto_detect))
		else $error("auto detect wrong");
	chk_io_supply: assert property (p_bit(4, o_io_supply_3v3))
		else $error("io supply wrong");
	chk_pass_bit: assert property (p_bit(3, o_pass_through_en))
		else $error("pass-through wrong");
	chk_edge_sel: assert property (p_bit(0, o_sample_edge_rising))
		else $error("edge select wrong");
	chk_clear_pulse: assert property (s_clr_wr |-> ##2 o_parity_cnt_clear ##1 !o_parity_cnt_clear)
		else $error("clear pulse wrong");
	chk_gain_atten: assert property (i_reg_wr && i_reg_addr == 8'h04 && i_reg_wdata == 8'h0F |-> ##2 o_manual_atten_tenths == 8'h50)
		else $error("attenuation decode wrong");
	chk_fwd_cause: assert property (o_fwd_req |-> $past(i_rmt_wr_req))
		else $error("forward without request");
	chk_ack_cause: assert property (o_local_ack |-> o_fwd_req || $past(i_rmt_ack))
		else $error("ack without cause");
	chk_rd_answer: assert property (i_reg_rd |=> o_reg_rvalid)
		else $error("read not answered");
	chk_unmapped_rd: assert property (i_reg_rd && i_reg_addr == 8'h05 |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind dcr_config_eq dcr_config_eq_assertions i_chk (
	.i_sys_clk(i_sys_clk),
	.i_rst(i_rst),
	.i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata),
	.i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata),
	.o_reg_rvalid(o_reg_rvalid),
	.i_rmt_wr_req(i_rmt_wr_req),
	.i_rmt_ack(i_rmt_ack),
	.o_local_ack(o_local_ack),
	.o_fwd_req(o_fwd_req),
	.o_parity_check_en(o_parity_check_en),
	.o_crc_gen_en(o_crc_gen_en),
	.o_io_auto_detect(o_io_auto_detect),
	.o_io_supply_3v3(o_io_supply_3v3),
	.o_pass_through_en(o_pass_through_en),
	.o_sample_edge_rising(o_sample_edge_rising),
	.o_parity_cnt_clear(o_parity_cnt_clear),
	.o_manual_atten_tenths(o_manual_atten_tenths)
);
`default_nettype wire

// >>> tb/dcr_remote_ser_model.sv
// remote serializer model: acknowledges each forwarded write after a set delay
`timescale 1ns/10ps
`default_nettype none
module dcr_remote_ser_model (
	// clock
	input wire logic i_sys_clk,
	// forwarded write and delay choice
	input wire logic i_fwd_req,
	input wire logic [6:0] i_fwd_dev,
	input wire logic [3:0] i_delay,
	// answer and observations
	output var logic o_rmt_ack = 1'b0,
	output var logic [6:0] o_last_dev = 7'h00,
	output var logic [7:0] o_ack_cnt = 8'h00
);
	logic [4:0] cnt = 5'h00; // cycles left before acknowledging
	// delay is reloaded on every forward, so a slow answer is really slow
	always @(posedge i_sys_clk) begin
		o_rmt_ack <= (cnt == 5'h01);
		if (cnt == 5'h01) o_ack_cnt <= o_ack_cnt + 8'h01;
		if (i_fwd_req) begin
			cnt <= {1'b0, i_delay} + 5'h01;
			o_last_dev <= i_fwd_dev; // address as seen across the link
		end else if (cnt != 5'h00) begin
			cnt <= cnt - 5'h01;
		end
	end
endmodule
`default_nettype wire

// >>> tb/dcr_config_eq_tb.sv
// self-checking bench for the config and gain register bank
`timescale 1ns/10ps
`default_nettype none
module dcr_config_eq_tb;
	logic clk = 0, rst = 1, wr = 0, rd = 0, rq = 0, byp = 0, lock = 0, fidv = 1;
	logic [7:0] addr = 8'h00, wd = 8'h00, agn = 8'h5A;
	logic [6:0] fid = 7'h11;
	logic [3:0] dly = 4'h0;
	wire [7:0] rdat, gain, atn, acnt;
	wire [6:0] fdev, ldev;
	wire [5:0] cfg; // parity, crc, autodet, 3v3, pass, edge
	wire rv, ack, lack, lnak, freq, clr, lkd;
	int error_cnt = 0, checked = 0, cyc = 0;
	dcr_config_eq i_dut (.i_sys_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wd),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .o_reg_rvalid(rv), .i_rx_lock(lock),
		.i_fwd_ser_id(fid), .i_fwd_ser_id_valid(fidv), .i_aeq_bypass(byp), .i_adaptive_gain(agn),
		.o_line_gain(gain), .o_manual_atten_tenths(atn), .i_rmt_wr_req(rq), .i_rmt_ack(ack),
		.o_local_ack(lack), .o_local_nak(lnak), .o_fwd_req(freq), .o_fwd_dev(fdev),
		.o_parity_check_en(cfg[5]), .o_crc_gen_en(cfg[4]), .o_io_auto_detect(cfg[3]),
		.o_io_supply_3v3(cfg[2]), .o_pass_through_en(cfg[1]), .o_sample_edge_rising(cfg[0]),
		.o_parity_cnt_clear(clr), .o_rx_locked(lkd));
	dcr_remote_ser_model i_rmt (.i_sys_clk(clk), .i_fwd_req(freq), .i_fwd_dev(fdev),
		.i_delay(dly), .o_rmt_ack(ack), .o_last_dev(ldev), .o_ack_cnt(acnt));
	always #5 clk = ~clk;
	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			report_and_stop;
		end
	end
	task automatic chk(input logic [7:0] got, exp, input string m);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// one-cycle write strobe, driven off the sampling edge
	task automatic wreg(input logic [7:0] a, d);
		@(negedge clk);
		addr = a;
		wd = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
	endtask
	// read valid stands one cycle only, so the answer is taken right away
	task automatic rreg(input logic [7:0] a, exp);
		@(negedge clk);
		addr = a;
		rd = 1;
		@(negedge clk);
		rd = 0;
		chk({7'h00, rv}, 8'h01, "rvalid");
		chk(rdat, exp, "rdata");
	endtask
	// remote write: exp3 = {fwd, ack, nak} next cycle, n = late acks
	task automatic rmt(input logic [2:0] exp3, input logic [7:0] n);
		logic [7:0] k;
		k = 0;
		@(negedge clk);
		rq = 1;
		@(negedge clk);
		rq = 0;
		chk({5'h00, freq, lack, lnak}, {5'h00, exp3}, "remote answer");
		repeat (12) begin
			@(negedge clk);
			k += lack;
		end
		chk(k, n, "late acks");
	endtask
	task automatic t_reset;
		rreg(8'h03, 8'hE9);
		rreg(8'h04, 8'h00);
		chk({2'b00, cfg}, 8'h3B, "reset levels");
		chk({7'h00, lkd}, 8'h00, "unlocked after reset");
		wreg(8'h05, 8'hFF);
		rreg(8'h05, 8'h00);
		$display("t_reset done");
	endtask
	task automatic t_cfg;
		logic [7:0] v[6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h01};
		for (int i = 0; i < 6; i++) begin
			wreg(8'h03, v[i]);
			repeat (2) @(negedge clk);
			chk({2'b00, cfg}, 8'h20 >> i, "level");
			rreg(8'h03, v[i]);
		end
		$display("t_cfg done");
	endtask
	// written twice with no zero between, each must clear again
	task automatic t_clear;
		repeat (2) begin
			wreg(8'h03, 8'h02);
			@(negedge clk);
			chk({7'h00, clr}, 8'h01, "clear pulse");
			rreg(8'h03, 8'h00);
		end
		$display("t_clear done");
	endtask
	task automatic t_gain;
		logic [7:0] c[8] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h02};
		logic [7:0] t[8] = '{8'h00, 8'h2D, 8'h41, 8'h4B, 8'h50, 8'h6E, 8'h7D, 8'hFF};
		byp = 1;
		for (int i = 0; i < 8; i++) begin
			wreg(8'h04, c[i]);
			repeat (4) @(negedge clk);
			chk(atn, t[i], "attenuation");
			chk(gain, c[i], "manual gain");
			rreg(8'h04, c[i]);
		end
		byp = 0;
		repeat (6) @(negedge clk);
		chk(gain, 8'h5A, "adaptive gain");
		$display("t_gain done");
	endtask
	task automatic t_remote;
		lock = 1;
		repeat (4) @(negedge clk);
		chk({7'h00, lkd}, 8'h01, "lock level");
		wreg(8'h06, 8'h55);
		repeat (3) @(negedge clk);
		rreg(8'h06, 8'h55);
		wreg(8'h03, 8'h0C);
		rmt(3'h6, 8'h00);
		chk({1'b0, ldev}, 8'h2A, "retarget");
		dly = 4'h5;
		wreg(8'h03, 8'h08);
		rmt(3'h4, 8'h01);
		chk(acnt, 8'h02, "far acks");
		wreg(8'h03, 8'h04);
		rmt(3'h1, 8'h00);
		wreg(8'h06, 8'h00);
		repeat (3) @(negedge clk);
		rreg(8'h06, 8'h22);
		lock = 0;
		repeat (4) @(negedge clk);
		chk({7'h00, lkd}, 8'h00, "lock lost");
		$display("t_remote done");
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst = 0;
		t_reset;
		t_cfg;
		t_clear;
		t_gain;
		t_remote;
		report_and_stop;
	end
endmodule
`default_nettype wire
